// >>> logic/cbx_pkg.sv
/*
  Constants, register map, instruction fields and state type for the branch/OR/increment/shift execution block.
  Assumes a 32-bit APB slave port with 8-bit byte addresses and a 100 MHz pclk.
*/
// Summary of operation
// - jump loads its 11-bit operand into program counter bits 10..0
// - jump fills program counter bits 14..11 from upper latch bits 6..3
// - jump takes two instruction cycles and leaves carry and zero alone
// - or-literal ORs accumulator with 8-bit operand into accumulator, only zero changes
// - increment adds one to the file register, result to destination, only zero changes
// - or-file ORs accumulator with file register, result to destination, only zero changes
// - destination bit 0 selects accumulator, 1 selects the addressed file register (0..127)
// - left shift: bit 7 to carry, bits 6..0 up one, zero into bit 0
// - right shift: zero into bit 7, bits 7..1 down one, bit 0 to carry
package cbx_pkg;
   localparam int          DATA_W      = 32;
   localparam int          ADDR_W      = 8;
   localparam int          PC_W        = 15;
   localparam int          LATCH_W     = 7;
   localparam int          INSTR_W     = 16;
   localparam int          FA_W        = 7;
   localparam int          FILE_DEPTH  = 128;
   // register byte offsets
   localparam logic [7:0]  OFS_INSTR   = 8'h00;
   localparam logic [7:0]  OFS_ACC     = 8'h04;
   localparam logic [7:0]  OFS_STATUS  = 8'h08;
   localparam logic [7:0]  OFS_PC      = 8'h0C;
   localparam logic [7:0]  OFS_LATCH   = 8'h10;
   localparam logic [7:0]  OFS_FADDR   = 8'h14;
   localparam logic [7:0]  OFS_FDATA   = 8'h18;
   // status fields
   localparam int          ST_C        = 0;
   localparam int          ST_Z        = 1;
   localparam int          ST_BUSY     = 8;
   // instruction word fields
   localparam int          OP_MSB      = 15;
   localparam int          OP_LSB      = 12;
   localparam int          K11_MSB     = 10;
   localparam int          D_BIT       = 7;
   localparam int          LAT_HI      = 6;
   localparam int          LAT_LO      = 3;
   localparam logic [3:0]  OP_JUMP     = 4'h1;
   localparam logic [3:0]  OP_ORL      = 4'h2;
   localparam logic [3:0]  OP_INC      = 4'h3;
   localparam logic [3:0]  OP_ORF      = 4'h4;
   localparam logic [3:0]  OP_LSL      = 4'h5;
   localparam logic [3:0]  OP_LSR      = 4'h6;
   localparam logic [7:0]  BYTE_ZERO   = 8'h00;
   localparam logic [7:0]  BYTE_ONE    = 8'h01;
   localparam logic [14:0] PC_STEP     = 15'h0001;
   localparam logic [14:0] PC_RESET    = 15'h0000;
   typedef enum logic [2:0] {
      CBX_IDLE  = 3'b001,
      CBX_EXEC  = 3'b010,
      CBX_JUMP2 = 3'b100
   } cbx_state_t;
endpackage

// >>> logic/cbx_alu_if.sv
/*
  Interface joining the execution top to its combinational result unit.
  Assumes both ends run in the pclk domain; no clocking here.
*/
`timescale 1ns/1ns
interface cbx_alu_if;
   logic [3:0]  op;
   logic [15:0] instr;
   logic [7:0]  fval;
   logic [7:0]  acc;
   logic        c_in;
   logic [14:0] pc;
   logic [6:0]  latch;
   logic [7:0]  result;
   logic        c_out;
   logic        z_out;
   logic        wr_acc;
   logic        wr_file;
   logic        wr_c;
   logic        wr_z;
   logic [14:0] pc_next;
   logic        is_jump;
   modport core (output op, instr, fval, acc, c_in, pc, latch,
                 input  result, c_out, z_out, wr_acc, wr_file, wr_c, wr_z, pc_next, is_jump);
   modport unit (input  op, instr, fval, acc, c_in, pc, latch,
                 output result, c_out, z_out, wr_acc, wr_file, wr_c, wr_z, pc_next, is_jump);
endinterface

// >>> logic/cbx_alu.sv
/*
  Combinational result unit: computes result, flags, write enables and next program counter.
  Assumes the caller latches its outputs during the execute cycle.
*/
`timescale 1ns/1ns
module cbx_alu (
   cbx_alu_if.unit a
);
   always_comb begin
      logic dst_file;
      dst_file  = a.instr[cbx_pkg::D_BIT];
      a.result  = cbx_pkg::BYTE_ZERO;
      a.c_out   = a.c_in;
      a.wr_acc  = 1'b0;
      a.wr_file = 1'b0;
      a.wr_c    = 1'b0;
      a.wr_z    = 1'b0;
      a.is_jump = 1'b0;
      a.pc_next = a.pc + cbx_pkg::PC_STEP;
      case (a.op)
         cbx_pkg::OP_JUMP: begin
            a.is_jump = 1'b1;
            a.pc_next = {a.latch[cbx_pkg::LAT_HI:cbx_pkg::LAT_LO],
                         a.instr[cbx_pkg::K11_MSB:0]};
         end
         cbx_pkg::OP_ORL: begin
            a.result = a.acc | a.instr[7:0];
            a.wr_acc = 1'b1;
            a.wr_z   = 1'b1;
         end
         cbx_pkg::OP_INC: begin
            a.result = 8'(a.fval + cbx_pkg::BYTE_ONE);
            a.wr_z   = 1'b1;
         end
         cbx_pkg::OP_ORF: begin
            a.result = a.acc | a.fval;
            a.wr_z   = 1'b1;
         end
         cbx_pkg::OP_LSL: begin
            a.result = {a.fval[6:0], 1'b0};
            a.c_out  = a.fval[7];
            a.wr_c   = 1'b1;
            a.wr_z   = 1'b1;
         end
         cbx_pkg::OP_LSR: begin
            a.result = {1'b0, a.fval[7:1]};
            a.c_out  = a.fval[0];
            a.wr_c   = 1'b1;
            a.wr_z   = 1'b1;
         end
         default: begin
         end
      endcase
      if (a.op == cbx_pkg::OP_INC || a.op == cbx_pkg::OP_ORF ||
          a.op == cbx_pkg::OP_LSL || a.op == cbx_pkg::OP_LSR) begin
         a.wr_acc  = ~dst_file;
         a.wr_file = dst_file;
      end
      a.z_out = (a.result == cbx_pkg::BYTE_ZERO);
   end
endmodule

// >>> logic/cbx_exec.sv
/*
  Execution top: APB register file, 128-byte file memory, accumulator, flags, program counter and sequencer.
  Assumes an APB master on pclk; software loads operands, then writes an instruction word to launch it.
*/
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ns
module cbx_exec (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);
   cbx_alu_if a ();

   cbx_pkg::cbx_state_t state_reg;
   logic [15:0] instr_reg;
   logic [7:0]  acc_reg;
   logic        c_reg;
   logic        z_reg;
   logic [14:0] pc_reg;
   logic [6:0]  latch_reg;
   logic [6:0]  faddr_reg;
   logic [7:0]  file_mem [cbx_pkg::FILE_DEPTH];
   logic [31:0] prdata_reg;
   logic        pready_reg;
   logic        pslverr_reg;
   logic        busy;
   logic        in_exec;
   logic        wr_take;
   logic        mapped;
   logic [31:0] rd_mux;
   logic [6:0]  op_faddr;

   cbx_alu u_alu (
      .a (a)
   );

   assign busy     = (state_reg != cbx_pkg::CBX_IDLE);
   assign in_exec  = (state_reg == cbx_pkg::CBX_EXEC);
   assign op_faddr = instr_reg[cbx_pkg::FA_W-1:0];
   assign a.op     = instr_reg[cbx_pkg::OP_MSB:cbx_pkg::OP_LSB];
   assign a.instr  = instr_reg;
   assign a.fval   = file_mem[op_faddr];
   assign a.acc    = acc_reg;
   assign a.c_in   = c_reg;
   assign a.pc     = pc_reg;
   assign a.latch  = latch_reg;

   // apb: one wait state, write and read both complete on the edge where pready is high
   assign wr_take = psel & penable & pready_reg & pwrite & ~busy;
   assign mapped  = (paddr == cbx_pkg::OFS_INSTR) || (paddr == cbx_pkg::OFS_ACC) ||
                    (paddr == cbx_pkg::OFS_STATUS) || (paddr == cbx_pkg::OFS_PC) ||
                    (paddr == cbx_pkg::OFS_LATCH) || (paddr == cbx_pkg::OFS_FADDR) ||
                    (paddr == cbx_pkg::OFS_FDATA);

   always_comb begin
      rd_mux = '0;
      case (paddr)
         cbx_pkg::OFS_INSTR:  rd_mux[15:0] = instr_reg;
         cbx_pkg::OFS_ACC:    rd_mux[7:0]  = acc_reg;
         cbx_pkg::OFS_STATUS: begin
            rd_mux[cbx_pkg::ST_C]    = c_reg;
            rd_mux[cbx_pkg::ST_Z]    = z_reg;
            rd_mux[cbx_pkg::ST_BUSY] = busy;
         end
         cbx_pkg::OFS_PC:     rd_mux[14:0] = pc_reg;
         cbx_pkg::OFS_LATCH:  rd_mux[6:0]  = latch_reg;
         cbx_pkg::OFS_FADDR:  rd_mux[6:0]  = faddr_reg;
         cbx_pkg::OFS_FDATA:  rd_mux[7:0]  = file_mem[faddr_reg];
         default:             rd_mux       = '0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= '0;
      end else begin
         pready_reg  <= psel & penable & ~pready_reg;
         pslverr_reg <= psel & penable & ~pready_reg & ~mapped;
         if (psel & penable & ~pready_reg & ~pwrite) begin
            prdata_reg <= rd_mux;
         end
      end
   end

   assign prdata  = prdata_reg;
   assign pready  = pready_reg;
   assign pslverr = pslverr_reg;

   // sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= cbx_pkg::CBX_IDLE;
         instr_reg <= '0;
      end else begin
         case (state_reg)
            cbx_pkg::CBX_IDLE: begin
               if (wr_take && paddr == cbx_pkg::OFS_INSTR) begin
                  instr_reg <= pwdata[15:0];
                  state_reg <= cbx_pkg::CBX_EXEC;
               end
            end
            cbx_pkg::CBX_EXEC: begin
               if (a.is_jump) begin
                  state_reg <= cbx_pkg::CBX_JUMP2;
               end else begin
                  state_reg <= cbx_pkg::CBX_IDLE;
               end
            end
            cbx_pkg::CBX_JUMP2: state_reg <= cbx_pkg::CBX_IDLE;
            default:            state_reg <= cbx_pkg::CBX_IDLE;
         endcase
      end
   end

   // accumulator, flags, program counter and latch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_reg   <= '0;
         c_reg     <= 1'b0;
         z_reg     <= 1'b0;
         pc_reg    <= cbx_pkg::PC_RESET;
         latch_reg <= '0;
         faddr_reg <= '0;
      end else if (in_exec) begin
         pc_reg <= a.pc_next;
         if (a.wr_acc) begin
            acc_reg <= a.result;
         end
         if (a.wr_c) begin
            c_reg <= a.c_out;
         end
         if (a.wr_z) begin
            z_reg <= a.z_out;
         end
      end else if (wr_take) begin
         case (paddr)
            cbx_pkg::OFS_ACC:    acc_reg   <= pwdata[7:0];
            cbx_pkg::OFS_STATUS: begin
               c_reg <= pwdata[cbx_pkg::ST_C];
               z_reg <= pwdata[cbx_pkg::ST_Z];
            end
            cbx_pkg::OFS_PC:     pc_reg    <= pwdata[14:0];
            cbx_pkg::OFS_LATCH:  latch_reg <= pwdata[6:0];
            cbx_pkg::OFS_FADDR:  faddr_reg <= pwdata[6:0];
            default: begin
            end
         endcase
      end
   end

   // file memory, no reset
   always_ff @(posedge pclk) begin
      if (in_exec && a.wr_file) begin
         file_mem[op_faddr] <= a.result;
      end else if (wr_take && paddr == cbx_pkg::OFS_FDATA) begin
         file_mem[faddr_reg] <= pwdata[7:0];
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic [3:0] op_now;
   assign op_now = a.op;

   a_jump_low_pc: assert property (in_exec && op_now == cbx_pkg::OP_JUMP
      |=> pc_reg[10:0] == $past(instr_reg[10:0])) else $error("jump low pc wrong");
   a_jump_high_pc: assert property (in_exec && op_now == cbx_pkg::OP_JUMP
      |=> pc_reg[14:11] == $past(latch_reg[6:3])) else $error("jump high pc wrong");
   a_jump_two_cycles: assert property (in_exec && op_now == cbx_pkg::OP_JUMP
      |=> state_reg == cbx_pkg::CBX_JUMP2 && $stable(c_reg) && $stable(z_reg)
      ##1 state_reg == cbx_pkg::CBX_IDLE) else $error("jump timing or flags wrong");
   a_orl_acc: assert property (in_exec && op_now == cbx_pkg::OP_ORL
      |=> acc_reg == ($past(acc_reg) | $past(instr_reg[7:0])) && $stable(c_reg))
      else $error("or literal wrong");
   a_inc_value: assert property (in_exec && op_now == cbx_pkg::OP_INC && !instr_reg[7]
      |=> acc_reg == 8'($past(a.fval) + cbx_pkg::BYTE_ONE) && $stable(c_reg))
      else $error("increment wrong");
   a_orf_acc: assert property (in_exec && op_now == cbx_pkg::OP_ORF && !instr_reg[7]
      |=> acc_reg == ($past(acc_reg) | $past(a.fval))) else $error("or file wrong");
   a_dest_file_keeps: assert property (in_exec && a.wr_file
      |=> $stable(acc_reg) ##0 file_mem[$past(op_faddr)] == $past(a.result))
      else $error("file destination wrong");
   a_lsl_carry: assert property (in_exec && op_now == cbx_pkg::OP_LSL
      |=> c_reg == $past(a.fval[7])) else $error("left shift carry wrong");
   a_lsr_carry: assert property (in_exec && op_now == cbx_pkg::OP_LSR
      |=> c_reg == $past(a.fval[0])) else $error("right shift carry wrong");
   a_zero_flag: assert property (in_exec && a.wr_z
      |=> z_reg == ($past(a.result) == cbx_pkg::BYTE_ZERO)) else $error("zero flag wrong");
   a_single_cycle: assert property (in_exec && op_now != cbx_pkg::OP_JUMP
      |=> state_reg == cbx_pkg::CBX_IDLE && pc_reg == 15'($past(pc_reg) + cbx_pkg::PC_STEP))
      else $error("single cycle step wrong");
   a_lsl_value: assert property (in_exec && op_now == cbx_pkg::OP_LSL && !instr_reg[cbx_pkg::D_BIT]
      |=> acc_reg == {$past(a.fval[6:0]), 1'b0}) else $error("left shift value wrong");
   a_lsr_value: assert property (in_exec && op_now == cbx_pkg::OP_LSR && !instr_reg[cbx_pkg::D_BIT]
      |=> acc_reg == {1'b0, $past(a.fval[7:1])}) else $error("right shift value wrong");
   a_orf_carry_keeps: assert property (in_exec && op_now == cbx_pkg::OP_ORF
      |=> $stable(c_reg)) else $error("or file touched carry");
   a_acc_untouched: assert property (in_exec && !a.wr_acc
      |=> $stable(acc_reg)) else $error("accumulator written without select");
   a_nop_flags_keep: assert property (in_exec && !a.wr_z && !a.is_jump
      |=> $stable(c_reg) && $stable(z_reg)) else $error("no-op touched flags");

   // apb handshake
   a_pready_pulse: assert property (pready_reg |=> !pready_reg) else $error("pready longer than one cycle");
   a_slverr_with_ready: assert property (pslverr_reg |-> pready_reg) else $error("slave error without pready");

   c_jump: cover property (in_exec && op_now == cbx_pkg::OP_JUMP);
   c_lsl_to_file: cover property (in_exec && op_now == cbx_pkg::OP_LSL && a.wr_file);
   c_orl_zero: cover property (in_exec && op_now == cbx_pkg::OP_ORL && a.z_out);
   c_unmapped: cover property (pslverr_reg);
   c_nop_op: cover property (in_exec && !a.wr_z && !a.is_jump);
endmodule

// >>> bench/cbx_exec_tb_top.sv
/*
  Self-checking bench for the execution block: runs each instruction kind over APB and checks the results.
  Assumes the APB slave answers with one wait state and that the bench alone drives every input.
*/
`timescale 1ns/1ns
module cbx_exec_tb_top;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] rd;
   logic        err;
   logic [14:0] exp_pc;
   int          errors;
   int          comparisons;

   cbx_exec cbx_exec_i (
      .pclk    (pclk),
      .presetn (presetn),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr)
   );

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task give_verdict;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // hold keeps the bus selected so the next setup follows at once
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input bit hold);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      chk("pready", 32'h1, {31'h0, pready});
      if (!hold) begin
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 1'b0);
   endtask

   task rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, 1'b0);
      chk(name, exp, rd);
   endtask

   task fset(input logic [6:0] f, input logic [7:0] v);
      wr(cbx_pkg::OFS_FADDR, {25'h0, f});
      wr(cbx_pkg::OFS_FDATA, {24'h0, v});
   endtask

   task fchk(input logic [6:0] f, input logic [7:0] v);
      wr(cbx_pkg::OFS_FADDR, {25'h0, f});
      rdc("file", cbx_pkg::OFS_FDATA, {24'h0, v});
   endtask

   // launch, read status at once to see how long busy lasts, then wait for idle
   task exec(input logic [15:0] ins, input logic busy_exp);
      int n;
      apb(1'b1, cbx_pkg::OFS_INSTR, {16'h0, ins}, 1'b1);
      apb(1'b0, cbx_pkg::OFS_STATUS, 32'h0, 1'b0);
      chk("busy", {31'h0, busy_exp}, {31'h0, rd[cbx_pkg::ST_BUSY]});
      n = 0;
      while (rd[cbx_pkg::ST_BUSY] !== 1'b0 && n < 10) begin
         apb(1'b0, cbx_pkg::OFS_STATUS, 32'h0, 1'b0);
         n++;
      end
      chk("idle", 32'h0, {31'h0, rd[cbx_pkg::ST_BUSY]});
   endtask

   task state(input logic [7:0] acc, input logic c, input logic z);
      rdc("acc", cbx_pkg::OFS_ACC, {24'h0, acc});
      rdc("status", cbx_pkg::OFS_STATUS, {30'h0, z, c});
      rdc("pc", cbx_pkg::OFS_PC, {17'h0, exp_pc});
      chk("slverr", 32'h0, {31'h0, err});
   endtask

   function automatic logic [15:0] fop(input logic [3:0] op, input logic d, input logic [6:0] f);
      return {op, 4'h0, d, f};
   endfunction

   task t_reset;
      rdc("acc", cbx_pkg::OFS_ACC, 32'h0);
      rdc("status", cbx_pkg::OFS_STATUS, 32'h0);
      rdc("pc", cbx_pkg::OFS_PC, 32'h0);
      rdc("latch", cbx_pkg::OFS_LATCH, 32'h0);
      rdc("unmapped", 8'h1C, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
   endtask

   task t_or_literal;
      wr(cbx_pkg::OFS_STATUS, 32'h1);
      wr(cbx_pkg::OFS_ACC, 32'h0);
      exec({cbx_pkg::OP_ORL, 4'h0, 8'h00}, 1'b0);
      exp_pc = exp_pc + 15'h1;
      state(8'h00, 1'b1, 1'b1);
      wr(cbx_pkg::OFS_ACC, 32'h50);
      exec({cbx_pkg::OP_ORL, 4'h0, 8'hA5}, 1'b0);
      exp_pc = exp_pc + 15'h1;
      state(8'hF5, 1'b1, 1'b0);
   endtask

   task t_increment;
      fset(7'h7F, 8'hFF);
      wr(cbx_pkg::OFS_ACC, 32'h33);
      exec(fop(cbx_pkg::OP_INC, 1'b0, 7'h7F), 1'b0);
      exp_pc = exp_pc + 15'h1;
      state(8'h00, 1'b1, 1'b1);
      fchk(7'h7F, 8'hFF);
      fset(7'h7F, 8'h7F);
      exec(fop(cbx_pkg::OP_INC, 1'b1, 7'h7F), 1'b0);
      exp_pc = exp_pc + 15'h1;
      state(8'h00, 1'b1, 1'b0);
      fchk(7'h7F, 8'h80);
   endtask

   task t_or_file;
      wr(cbx_pkg::OFS_ACC, 32'h0C);
      fset(7'h00, 8'h30);
      exec(fop(cbx_pkg::OP_ORF, 1'b1, 7'h00), 1'b0);
      exp_pc = exp_pc + 15'h1;
      state(8'h0C, 1'b1, 1'b0);
      fchk(7'h00, 8'h3C);
      wr(cbx_pkg::OFS_ACC, 32'h0);
      fset(7'h00, 8'h00);
      exec(fop(cbx_pkg::OP_ORF, 1'b0, 7'h00), 1'b0);
      exp_pc = exp_pc + 15'h1;
      state(8'h00, 1'b1, 1'b1);
   endtask

   task t_shifts;
      wr(cbx_pkg::OFS_STATUS, 32'h0);
      fset(7'h05, 8'h81);
      exec(fop(cbx_pkg::OP_LSL, 1'b0, 7'h05), 1'b0);
      exp_pc = exp_pc + 15'h1;
      state(8'h02, 1'b1, 1'b0);
      fchk(7'h05, 8'h81);
      wr(cbx_pkg::OFS_STATUS, 32'h0);
      fset(7'h06, 8'h01);
      exec(fop(cbx_pkg::OP_LSR, 1'b0, 7'h06), 1'b0);
      exp_pc = exp_pc + 15'h1;
      state(8'h00, 1'b1, 1'b1);
      fset(7'h06, 8'hFE);
      exec(fop(cbx_pkg::OP_LSR, 1'b1, 7'h06), 1'b0);
      exp_pc = exp_pc + 15'h1;
      state(8'h00, 1'b0, 1'b0);
      fchk(7'h06, 8'h7F);
   endtask

   task t_jump;
      wr(cbx_pkg::OFS_STATUS, 32'h3);
      wr(cbx_pkg::OFS_LATCH, 32'h55);
      exec({cbx_pkg::OP_JUMP, 1'b0, 11'h5A3}, 1'b1);
      exp_pc = {4'hA, 11'h5A3};
      state(8'h00, 1'b1, 1'b1);
      wr(cbx_pkg::OFS_LATCH, 32'h7F);
      exec({cbx_pkg::OP_JUMP, 1'b0, 11'h7FF}, 1'b1);
      exp_pc = 15'h7FFF;
      state(8'h00, 1'b1, 1'b1);
      wr(cbx_pkg::OFS_ACC, 32'h01);
      exec({cbx_pkg::OP_ORL, 4'h0, 8'h00}, 1'b0);
      exp_pc = 15'h0000;
      state(8'h01, 1'b1, 1'b0);
   endtask

   // an undecoded op code steps the pc and leaves accumulator and flags alone
   task t_no_op;
      wr(cbx_pkg::OFS_STATUS, 32'h2);
      exec(16'h0055, 1'b0);
      exp_pc = exp_pc + 15'h1;
      state(8'h01, 1'b0, 1'b1);
   endtask

   initial begin
      #100000;
      errors++;
      $display("wrong value watchdog expected done seen timeout");
      give_verdict;
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      errors = 0;
      comparisons = 0;
      exp_pc = 15'h0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset;
      t_or_literal;
      t_increment;
      t_or_file;
      t_shifts;
      t_jump;
      t_no_op;
      give_verdict;
   end
endmodule
